// file: src/led_sink_control_regs.sv
// register bank for the two LED sinks, function pin status and boot configuration
`timescale 1ns/1ps
module led_sink_control_regs (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrEn,
    input  wire logic [7:0] regWrData,
    input  wire logic       regRdEn,
    output logic [7:0]      regRdData,
    input  wire logic [1:0] sinkCurrentStepSize,
    input  wire logic       chargerStatus,
    input  wire logic [4:0] mpcPin,
    input  wire logic [1:0] functionPinActive,
    input  wire logic [7:0] bootConfigStrap,
    output logic            firstSinkEnable,
    output logic [8:0]      firstSinkCurrent,
    output logic            secondSinkEnable,
    output logic [8:0]      secondSinkCurrent
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] firstControl;
        logic [7:0] secondControl;
        logic [7:0] pinStatus;
        logic [7:0] bootConfig;
        logic       bootCaptured;
        logic [7:0] rdData;
    } regs_state_s;

    regs_state_s state_ff;
    regs_state_s nxt_state;

    logic [7:0] sinkControl [2];
    logic [1:0] sinkEnableVec;
    logic [8:0] sinkCurrentVec [2];

    function automatic logic regHit(input logic [7:0] addr, input logic [7:0] ofs);
        regHit = (addr == ofs);
    endfunction

    // ------------------------------------------------------------------
    // register update and readback
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        if (regWrEn && regHit(regAddr, led_sink_pkg::FIRST_SINK_CONTROL_OFS)) begin
            nxt_state.firstControl = regWrData;
        end
        if (regWrEn && regHit(regAddr, led_sink_pkg::SECOND_SINK_CONTROL_OFS)) begin
            nxt_state.secondControl = regWrData;
        end
        // writes to the status and boot registers are dropped
        nxt_state.pinStatus = led_sink_pkg::STATUS_RST;
        nxt_state.pinStatus[led_sink_pkg::FIRST_FUNCTION_PIN_BIT]  = functionPinActive[0];
        nxt_state.pinStatus[led_sink_pkg::SECOND_FUNCTION_PIN_BIT] = functionPinActive[1];
        // strap is taken once, the first cycle after reset is released
        if (!state_ff.bootCaptured) begin
            nxt_state.bootConfig   = bootConfigStrap;
            nxt_state.bootCaptured = 1'b1;
        end
        if (regRdEn) begin
            if (regHit(regAddr, led_sink_pkg::FIRST_SINK_CONTROL_OFS)) begin
                nxt_state.rdData = state_ff.firstControl;
            end else if (regHit(regAddr, led_sink_pkg::SECOND_SINK_CONTROL_OFS)) begin
                nxt_state.rdData = state_ff.secondControl;
            end else if (regHit(regAddr, led_sink_pkg::FUNCTION_PIN_STATUS_OFS)) begin
                nxt_state.rdData = state_ff.pinStatus;
            end else if (regHit(regAddr, led_sink_pkg::BOOT_CONFIGURATION_OFS)) begin
                nxt_state.rdData = state_ff.bootConfig;
            end else begin
                nxt_state.rdData = led_sink_pkg::READ_UNMAPPED;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff.firstControl  <= led_sink_pkg::SINK_CONTROL_RST;
            state_ff.secondControl <= led_sink_pkg::SINK_CONTROL_RST;
            state_ff.pinStatus     <= led_sink_pkg::STATUS_RST;
            state_ff.bootConfig    <= led_sink_pkg::STATUS_RST;
            state_ff.bootCaptured  <= 1'b0;
            state_ff.rdData        <= led_sink_pkg::READ_UNMAPPED;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign regRdData = state_ff.rdData;

    // ------------------------------------------------------------------
    // sinks
    // ------------------------------------------------------------------
    assign sinkControl[0] = state_ff.firstControl;
    assign sinkControl[1] = state_ff.secondControl;

    for (genvar i = 0; i < 2; i++) begin : g_sink
        sink_channel u_sink (
            .clk_sys       (clk_sys),
            .rst_n         (rst_n),
            .controlValue  (sinkControl[i]),
            .stepSize      (sinkCurrentStepSize),
            .chargerStatus (chargerStatus),
            .mpcPin        (mpcPin),
            .sinkEnable    (sinkEnableVec[i]),
            .sinkCurrent   (sinkCurrentVec[i])
        );
    end

    assign firstSinkEnable   = sinkEnableVec[0];
    assign firstSinkCurrent  = sinkCurrentVec[0];
    assign secondSinkEnable  = sinkEnableVec[1];
    assign secondSinkCurrent = sinkCurrentVec[1];

endmodule

// file: src/led_sink_pkg.sv
// constants for the two-sink LED control register bank
package led_sink_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] FIRST_SINK_CONTROL_OFS   = 8'h7B;
    localparam logic [7:0] SECOND_SINK_CONTROL_OFS  = 8'h7C;
    localparam logic [7:0] FUNCTION_PIN_STATUS_OFS  = 8'h7D;
    localparam logic [7:0] BOOT_CONFIGURATION_OFS   = 8'h7E;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] SINK_CONTROL_RST         = 8'h00;
    localparam logic [7:0] STATUS_RST               = 8'h00;
    localparam logic [7:0] READ_UNMAPPED            = 8'h00;

    // ------------------------------------------------------------------
    // sink control fields
    // ------------------------------------------------------------------
    localparam int         SOURCE_SELECT_LSB        = 5;
    localparam int         SOURCE_SELECT_W          = 3;
    localparam int         STEP_COUNT_LSB           = 0;
    localparam int         STEP_COUNT_W             = 5;
    localparam int         CURRENT_W                = 9;

    localparam logic [2:0] SOURCE_OFF               = 3'h0;
    localparam logic [2:0] SOURCE_ON                = 3'h1;
    localparam logic [2:0] SOURCE_CHARGER           = 3'h2;
    localparam logic [2:0] SOURCE_PIN_BASE          = 3'h3;
    localparam int         PIN_COUNT                = 5;

    // step size codes and their currents in tenths of a milliamp
    localparam logic [1:0] STEP_CODE_SMALL          = 2'h0;
    localparam logic [1:0] STEP_CODE_MEDIUM         = 2'h1;
    localparam logic [1:0] STEP_CODE_LARGE          = 2'h2;
    localparam logic [3:0] STEP_TENTHS_SMALL        = 4'h6;
    localparam logic [3:0] STEP_TENTHS_MEDIUM       = 4'hA;
    localparam logic [3:0] STEP_TENTHS_LARGE        = 4'hC;
    localparam logic [3:0] STEP_TENTHS_NONE         = 4'h0;

    // ------------------------------------------------------------------
    // boot configuration and pin status fields
    // ------------------------------------------------------------------
    localparam int         POWER_RESET_CFG_LSB      = 4;
    localparam int         SOFT_RESET_RETAIN_BIT    = 3;
    localparam int         BOOT_DELAY_LSB           = 1;
    localparam int         RETRY_OPTION_BIT         = 0;
    localparam int         FIRST_FUNCTION_PIN_BIT   = 0;
    localparam int         SECOND_FUNCTION_PIN_BIT  = 1;

endpackage

// file: src/sink_channel.sv
// one LED current sink: source decode and current setting, both registered
`timescale 1ns/1ps
module sink_channel (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic [7:0] controlValue,
    input  wire logic [1:0] stepSize,
    input  wire logic       chargerStatus,
    input  wire logic [4:0] mpcPin,
    output logic            sinkEnable,
    output logic [8:0]      sinkCurrent
);

    typedef struct packed {
        logic       enable;
        logic [8:0] current;
    } sink_state_s;

    sink_state_s state_ff;
    sink_state_s nxt_state;

    logic [2:0] sourceSelect;
    logic [4:0] stepCount;
    logic [2:0] pinIndex;
    logic [3:0] stepTenths;

    assign sourceSelect = controlValue[led_sink_pkg::SOURCE_SELECT_LSB +: led_sink_pkg::SOURCE_SELECT_W];
    assign stepCount    = controlValue[led_sink_pkg::STEP_COUNT_LSB +: led_sink_pkg::STEP_COUNT_W];
    assign pinIndex     = sourceSelect - led_sink_pkg::SOURCE_PIN_BASE;

    always_comb begin
        nxt_state = state_ff;
        // source select decode
        case (sourceSelect)
            led_sink_pkg::SOURCE_OFF:     nxt_state.enable = 1'b0;
            led_sink_pkg::SOURCE_ON:      nxt_state.enable = 1'b1;
            led_sink_pkg::SOURCE_CHARGER: nxt_state.enable = chargerStatus;
            default:                      nxt_state.enable = mpcPin[pinIndex];
        endcase
        // code 3 of the step size is undefined; the sink is held at zero
        case (stepSize)
            led_sink_pkg::STEP_CODE_SMALL:  stepTenths = led_sink_pkg::STEP_TENTHS_SMALL;
            led_sink_pkg::STEP_CODE_MEDIUM: stepTenths = led_sink_pkg::STEP_TENTHS_MEDIUM;
            led_sink_pkg::STEP_CODE_LARGE:  stepTenths = led_sink_pkg::STEP_TENTHS_LARGE;
            default:                        stepTenths = led_sink_pkg::STEP_TENTHS_NONE;
        endcase
        nxt_state.current = 9'(({4'h0, stepCount} + 9'h001) * {5'h00, stepTenths});
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sinkEnable  = state_ff.enable;
    assign sinkCurrent = state_ff.current;

endmodule

// file: test/led_sink_control_regs_asserts.sv
// port-level assertions for the LED sink register bank
`timescale 1ns/1ps
module led_sink_control_regs_chk (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic [7:0] regAddr,
    input wire logic       regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic [1:0] sinkCurrentStepSize,
    input wire logic       chargerStatus,
    input wire logic [4:0] mpcPin,
    input wire logic [1:0] functionPinActive,
    input wire logic [7:0] bootConfigStrap,
    input wire logic       firstSinkEnable,
    input wire logic [8:0] firstSinkCurrent,
    input wire logic       secondSinkEnable,
    input wire logic [8:0] secondSinkCurrent
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // step size in tenths of a milliamp, code 3 gives no current
    function automatic logic [8:0] tenths(input logic [1:0] c);
        return (c == 2'h0) ? 9'h006 : (c == 2'h1) ? 9'h00A : (c == 2'h2) ? 9'h00C : 9'h000;
    endfunction
    AST_CUR_FIRST: assert property (regWrEn && regAddr == 8'h7B |=> ##1
        firstSinkCurrent == ($past(regWrData[4:0], 2) + 9'h001) * tenths($past(sinkCurrentStepSize)))
        else $error("first sink current does not follow step count");
    AST_EN_FIRST: assert property (regWrEn && regAddr == 8'h7B && regWrData[7:6] == 2'h0
        |=> ##1 firstSinkEnable == $past(regWrData[5], 2)) else $error("first sink on/off wrong");
    AST_STEP_NONE: assert property (sinkCurrentStepSize == 2'h3
        |=> secondSinkCurrent == 9'h000) else $error("second sink current not zero");
    AST_RD_SECOND: assert property (regWrEn && regAddr == 8'h7C ##1
        regRdEn && regAddr == 8'h7C && !regWrEn |=> regRdData == $past(regWrData, 2))
        else $error("second sink control readback wrong");
    AST_PIN_STATUS: assert property (regRdEn && regAddr == 8'h7D && $past(rst_n)
        && $stable(functionPinActive) |=> regRdData == {6'h00, $past(functionPinActive)})
        else $error("pin status readback wrong");
    AST_BOOT_RO: assert property (regRdEn && regAddr == 8'h7E && $past(rst_n)
        |=> regRdData == $past(bootConfigStrap)) else $error("boot configuration readback wrong");
    cover property (regWrEn && regAddr == 8'h7B);
    cover property (regRdEn && regAddr == 8'h7D);
    cover property (sinkCurrentStepSize == 2'h3);
endmodule

// file: test/led_sink_control_regs_tb.sv
// self-checking bench for the LED sink register bank
`timescale 1ns/1ps
module led_sink_control_regs_tb;
    logic       clk_sys   = 1'b0;
    logic       rst_n     = 1'b0;
    logic [7:0] regAddr   = 8'h00;
    logic       regWrEn   = 1'b0;
    logic [7:0] regWrData = 8'h00;
    logic       regRdEn   = 1'b0;
    logic [7:0] regRdData;
    logic [1:0] stepSz    = 2'h0;
    logic       chg       = 1'b0;
    logic [4:0] mpc       = 5'h00;
    logic [1:0] fnPin     = 2'h0;
    logic [7:0] strap     = 8'hA5;
    logic       en1;
    logic       en2;
    logic [8:0] cur1;
    logic [8:0] cur2;
    logic [8:0] tn [4]    = '{9'h006, 9'h00A, 9'h00C, 9'h000};
    int         err_total = 0;
    int         n_checks  = 0;
    int         cycles    = 0;
    always #2.5 clk_sys = ~clk_sys;
    led_sink_control_regs dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .sinkCurrentStepSize(stepSz), .chargerStatus(chg), .mpcPin(mpc),
        .functionPinActive(fnPin), .bootConfigStrap(strap), .firstSinkEnable(en1),
        .firstSinkCurrent(cur1), .secondSinkEnable(en2), .secondSinkCurrent(cur2));
    // --------------------------------------------------------------
    // access and compare tasks, entered just after a falling edge; final_report is also entered at a rising edge by the timeout
    // --------------------------------------------------------------
    task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk_sys);
        regWrEn = 1'b0;
    endtask
    // a read straight after a write also gives the sink outputs their two edges;
    // the idle edge at the end keeps a following read from re-raising the strobe at once
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk_sys);
        regRdEn = 1'b0;
        chk(nm, {1'b0, exp}, {1'b0, regRdData});
        @(negedge clk_sys);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 1000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        rd(8'h7B, 8'h00, "first ctl reset");
        rd(8'h10, 8'h00, "unmapped");
        wr(8'h7B, 8'h38);
        rd(8'h7B, 8'h38, "first ctl");
        for (int s = 0; s < 4; s++) begin
            stepSz = s[1:0];
            @(negedge clk_sys);
            chk("first cur", 9'h019 * tn[s], cur1);
            chk("first on", 9'h001, {8'h00, en1});
        end
        stepSz = 2'h1;
        wr(8'h7C, 8'h58);
        rd(8'h7C, 8'h58, "second ctl");
        for (int c = 0; c < 2; c++) begin
            chg = c[0];
            @(negedge clk_sys);
            chk("second cur", 9'h019 * tn[1], cur2);
            chk("second charger", {8'h00, c[0]}, {8'h00, en2});
        end
        for (int s = 3; s < 8; s++) begin
            wr(8'h7B, {s[2:0], 5'h00});
            mpc = 5'h01 << (s - 3);
            @(negedge clk_sys);
            chk("first pin on", 9'h001, {8'h00, en1});
            chk("first cur min", tn[1], cur1);
            mpc = ~mpc;
            @(negedge clk_sys);
            chk("first pin off", 9'h000, {8'h00, en1});
        end
        wr(8'h7B, 8'h00);
        mpc = 5'h1F;
        repeat (2) @(negedge clk_sys);
        chk("first off", 9'h000, {8'h00, en1});
        for (int p = 1; p < 3; p++) begin
            fnPin = p[1:0];
            repeat (2) @(negedge clk_sys);
            rd(8'h7D, {6'h00, p[1:0]}, "pin status");
        end
        wr(8'h7E, 8'h00);
        rd(8'h7E, 8'hA5, "boot cfg");
        wr(8'h7D, 8'hFF);
        rd(8'h7D, 8'h02, "pin status ro");
        final_report();
    end
endmodule
bind led_sink_control_regs led_sink_control_regs_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .sinkCurrentStepSize(sinkCurrentStepSize),
    .chargerStatus(chargerStatus), .mpcPin(mpcPin), .functionPinActive(functionPinActive),
    .bootConfigStrap(bootConfigStrap), .firstSinkEnable(firstSinkEnable),
    .firstSinkCurrent(firstSinkCurrent), .secondSinkEnable(secondSinkEnable),
    .secondSinkCurrent(secondSinkCurrent));
